// ### logic/cmp_change.sv
// Synchroniser and mismatch detector for the two comparator results.
// Assumes results arrive asynchronously and access is a one-cycle pulse.
`timescale 1ns/10ps
module cmp_change (
    input  wire logic clk,
    input  wire logic rst_n,
    cmp_chg_if.detect chg
);
    import cmp_pkg::*;

    logic [1:0] sync_first;
    logic [1:0] sync_second;
    logic [1:0] sync_third;
    logic [1:0] stable;
    logic [1:0] latched;
    logic [1:0] next_stable;

    // ==============================================================
    // Three-stage synchroniser; a level counts once the second and third stages agree
    assign next_stable = (sync_second == sync_third) ? sync_second : stable;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync_first  <= 2'h0;
            sync_second <= 2'h0;
            sync_third  <= 2'h0;
            stable      <= 2'h0;
        end else begin
            sync_first  <= chg.result_async;
            sync_second <= sync_first;
            sync_third  <= sync_second;
            stable      <= next_stable;
        end
    end

    // ==============================================================
    // Reference taken on every access; a change landing in the
    // access cycle is absorbed here and so raises no flag
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            latched <= 2'h0;
        end else if (chg.access) begin
            latched <= next_stable;
        end
    end

    assign chg.result_stable = stable;
    assign chg.mismatch      = (stable != latched);

    // ==============================================================
    // Checks
    access_ends_a: assert property (@(posedge clk) disable iff (!rst_n)
        chg.access ##1 $stable(stable) |-> !chg.mismatch)
        else $error("mismatch survived a register access");
    sync_agree_a: assert property (@(posedge clk) disable iff (!rst_n)
        (sync_second != sync_third) |=> $stable(stable))
        else $error("stable result moved while stages disagreed");
endmodule

// ### logic/cmp_chg_if.sv
// Carrier between the control logic and the change detector.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
interface cmp_chg_if;
    logic [1:0] result_async;
    logic       access;
    logic [1:0] result_stable;
    logic       mismatch;
    modport detect (input result_async, input access, output result_stable, output mismatch);
    modport ctrl (output result_async, output access, input result_stable, input mismatch);
endinterface

// ### logic/cmp_ctrl.sv
// Digital control of a dual comparator and its reference ladder.
// Assumes a single-cycle register port with read data one cycle later.
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/10ps
module cmp_ctrl (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    input  wire logic       first_raw,
    input  wire logic       second_raw,
    input  wire logic [7:0] port_pin_in,
    output logic      [7:0] port_pin_out,
    output logic      [7:0] port_pin_oe_n,
    input  wire logic       sleep,
    output logic            irq_request,
    output logic            wake_request,
    output logic      [2:0] comparator_mode_field,
    output logic            input_switch,
    output logic            ladder_power,
    output logic            ladder_pin_output,
    output logic            ladder_range,
    output logic      [3:0] ladder_tap_value,
    output logic            ladder_to_comparators
);
    import cmp_pkg::*;

    // ==============================================================
    // Address decode helper
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
        hit = (addr == ofs);
    endfunction

    // ==============================================================
    // Register state
    logic [5:0] ctrl_bits;
    logic [7:0] ladder_ctrl;
    logic [7:0] irq_global;
    logic [7:0] flags_second;
    logic [7:0] enables_second;
    logic [7:0] port_dir;
    logic [7:0] port_latch;
    logic [7:0] pin_s1;
    logic [7:0] pin_s2;
    logic [7:0] pin_s3;
    logic [7:0] pin_stable;

    // ==============================================================
    // Named decode wires
    logic       sel_ctrl;
    logic       sel_ladder;
    logic       sel_global;
    logic       sel_flags;
    logic       sel_enables;
    logic       sel_dir;
    logic       sel_port;
    logic       wr_ctrl;
    logic       wr_flags;
    logic [2:0] mode;
    logic       cmp_active;
    logic       route_pins;
    logic [7:0] analog_pins;
    logic       first_result_async;
    logic       second_result_async;
    logic [7:0] ctrl_read;
    logic [7:0] port_read;
    logic [7:0] read_mux;
    logic       change_set;
    logic [7:0] next_flags;
    logic [7:0] next_pin_stable;

    cmp_chg_if chg ();

    assign sel_ctrl    = hit(reg_addr, OFS_CMP_CONTROL);
    assign sel_ladder  = hit(reg_addr, OFS_LADDER_CONTROL);
    assign sel_global  = hit(reg_addr, OFS_IRQ_GLOBAL);
    assign sel_flags   = hit(reg_addr, OFS_FLAGS_SECOND);
    assign sel_enables = hit(reg_addr, OFS_ENABLES_SECOND);
    assign sel_dir     = hit(reg_addr, OFS_PORT_A_DIR);
    assign sel_port    = hit(reg_addr, OFS_PORT_A_DATA);
    assign wr_ctrl     = reg_wr & sel_ctrl;
    assign wr_flags    = reg_wr & sel_flags;

    // ==============================================================
    // Comparator results; raw input is plus-above-minus from the
    // analog core, held low while the comparators are off
    assign mode                = ctrl_bits[2:0];
    assign cmp_active          = (mode != MODE_OFF);
    assign first_result_async  = (first_raw & cmp_active) ^ ctrl_bits[BIT_FIRST_INVERT];
    assign second_result_async = (second_raw & cmp_active) ^ ctrl_bits[BIT_SECOND_INVERT];

    assign chg.result_async = {second_result_async, first_result_async};
    assign chg.access       = (reg_rd | reg_wr) & sel_ctrl;

    cmp_change u_change (
        .clk   (clk),
        .rst_n (rst_n),
        .chg   (chg)
    );

    // ==============================================================
    // Control register; only reset touches it outside writes, so
    // sleep and wake leave it alone
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_bits <= RST_CMP_CONTROL[5:0];
        end else if (wr_ctrl) begin
            ctrl_bits <= reg_wdata[5:0];
        end
    end

    // Result bits come from the synchroniser, never from a write
    assign ctrl_read = {chg.result_stable[1], chg.result_stable[0], ctrl_bits};

    // ==============================================================
    // Ladder control register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ladder_ctrl <= RST_LADDER_CONTROL;
        end else if (reg_wr & sel_ladder) begin
            ladder_ctrl <= reg_wdata & ~(8'h01 << BIT_LADDER_UNUSED);
        end
    end

    assign ladder_power          = ladder_ctrl[BIT_LADDER_POWER];
    assign ladder_pin_output     = ladder_ctrl[BIT_LADDER_PIN];
    assign ladder_range          = ladder_ctrl[BIT_LADDER_RANGE];
    assign ladder_tap_value      = ladder_ctrl[3:0];
    assign ladder_to_comparators = ladder_power & (mode == MODE_LADDER_REF);
    assign comparator_mode_field = mode;
    assign input_switch          = ctrl_bits[BIT_INPUT_SWITCH];

    // ==============================================================
    // Enable and flag registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_global     <= RST_IRQ_GLOBAL;
            enables_second <= RST_ENABLES_SECOND;
        end else begin
            if (reg_wr & sel_global) begin
                irq_global <= reg_wdata;
            end
            if (reg_wr & sel_enables) begin
                enables_second <= reg_wdata & FLAGS_IMPL_MASK;
            end
        end
    end

    // Hardware set wins over a software clear in the same cycle
    assign change_set = chg.mismatch;
    always_comb begin
        next_flags = wr_flags ? (reg_wdata & FLAGS_IMPL_MASK) : flags_second;
        if (change_set) begin
            next_flags[BIT_CHANGE_FLAG] = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flags_second <= RST_FLAGS_SECOND;
        end else begin
            flags_second <= next_flags;
        end
    end

    // Flag is set regardless of enables; request needs all three
    assign irq_request  = flags_second[BIT_CHANGE_FLAG] & enables_second[BIT_CHANGE_FLAG]
                        & irq_global[BIT_PERIPH_EN] & irq_global[BIT_GLOBAL_EN];
    // Wake does not need the global enable, as in a sleeping core
    assign wake_request = sleep & flags_second[BIT_CHANGE_FLAG]
                        & enables_second[BIT_CHANGE_FLAG] & irq_global[BIT_PERIPH_EN];

    // ==============================================================
    // Port direction and output latch
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            port_dir   <= RST_PORT_A_DIR;
            port_latch <= RST_PORT_A_LATCH;
        end else begin
            if (reg_wr & sel_dir) begin
                port_dir <= reg_wdata | DIR_FORCED_MASK;
            end
            if (reg_wr & sel_port) begin
                port_latch <= reg_wdata;
            end
        end
    end

    // ==============================================================
    // Pin input synchronisers, one per pin
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_pin_sync
            assign next_pin_stable[gi] = (pin_s2[gi] == pin_s3[gi]) ? pin_s2[gi]
                                                                     : pin_stable[gi];
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    pin_s1[gi]     <= 1'b0;
                    pin_s2[gi]     <= 1'b0;
                    pin_s3[gi]     <= 1'b0;
                    pin_stable[gi] <= 1'b0;
                end else begin
                    pin_s1[gi]     <= port_pin_in[gi];
                    pin_s2[gi]     <= pin_s1[gi];
                    pin_s3[gi]     <= pin_s2[gi];
                    pin_stable[gi] <= next_pin_stable[gi];
                end
            end
        end
    endgenerate

    // ==============================================================
    // Pin use per mode; the ladder pin turns analog when driven
    assign route_pins  = PIN_OUT_MODES[mode];
    assign analog_pins = (!cmp_active ? ANALOG_PINS_NONE
                         : route_pins ? ANALOG_PINS_ROUTED : ANALOG_PINS_PLAIN)
                       | ({7'h00, ladder_pin_output} << PIN_LADDER);
    assign port_read   = pin_stable & ~analog_pins;

    // Routed results bypass the synchroniser on purpose: the pin
    // shows the comparator with no clock delay
    always_comb begin
        port_pin_out = port_latch;
        if (route_pins) begin
            port_pin_out[PIN_FIRST_OUT]  = first_result_async;
            port_pin_out[PIN_SECOND_OUT] = second_result_async;
        end
    end
    assign port_pin_oe_n = port_dir;

    // ==============================================================
    // Read mux; unmapped addresses read zero
    assign read_mux = sel_ctrl    ? ctrl_read
                    : sel_ladder  ? ladder_ctrl
                    : sel_global  ? irq_global
                    : sel_flags   ? flags_second
                    : sel_enables ? enables_second
                    : sel_dir     ? port_dir
                    : sel_port    ? port_read
                    : 8'h00;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= reg_rd ? read_mux : 8'h00;
        end
    end

    // ==============================================================
    // Checks
    result_ro_a: assert property (@(posedge clk) disable iff (!rst_n)
        reg_rd & sel_ctrl |=> reg_rdata[7:6] == $past(chg.result_stable))
        else $error("result bits read back wrong");
    pin_route_a: assert property (@(posedge clk) disable iff (!rst_n)
        route_pins |-> port_pin_out[PIN_FIRST_OUT] == first_result_async
                   && port_pin_out[PIN_SECOND_OUT] == second_result_async)
        else $error("routed pins do not carry results");
    pin_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
        port_pin_oe_n[PIN_FIRST_OUT] == port_dir[PIN_FIRST_OUT])
        else $error("pin enable ignores direction");
    invert_a: assert property (@(posedge clk) disable iff (!rst_n)
        cmp_active |-> first_result_async == (first_raw ^ ctrl_bits[BIT_FIRST_INVERT]))
        else $error("inversion not applied");
    analog_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
        reg_rd & sel_port |=> (reg_rdata & $past(analog_pins)) == 8'h00)
        else $error("analog pin read nonzero");
    flag_set_a: assert property (@(posedge clk) disable iff (!rst_n)
        chg.mismatch |=> flags_second[BIT_CHANGE_FLAG])
        else $error("mismatch did not set flag");
    flag_write_a: assert property (@(posedge clk) disable iff (!rst_n)
        wr_flags & reg_wdata[BIT_CHANGE_FLAG] |=> flags_second[BIT_CHANGE_FLAG])
        else $error("software set of flag failed");
    irq_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
        !irq_global[BIT_GLOBAL_EN] |-> !irq_request)
        else $error("request without global enable");
    ladder_mode_a: assert property (@(posedge clk) disable iff (!rst_n)
        ladder_to_comparators |-> mode == MODE_LADDER_REF)
        else $error("ladder feeds comparators in wrong mode");
    unused_bit_a: assert property (@(posedge clk) disable iff (!rst_n)
        reg_rd & sel_ladder |=> !reg_rdata[BIT_LADDER_UNUSED])
        else $error("unused ladder bit reads one");
    wake_a: assert property (@(posedge clk) disable iff (!rst_n)
        wake_request |-> sleep && flags_second[BIT_CHANGE_FLAG])
        else $error("wake without sleep and flag");
    sleep_keep_a: assert property (@(posedge clk) disable iff (!rst_n)
        !wr_ctrl |=> $stable(ctrl_bits))
        else $error("control changed without a write");
    irq_enables_a: assert property (@(posedge clk) disable iff (!rst_n)
        irq_request |-> flags_second[BIT_CHANGE_FLAG] && enables_second[BIT_CHANGE_FLAG]
                     && irq_global[BIT_PERIPH_EN])
        else $error("request without flag or enables");
    flag_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
        wr_flags && !reg_wdata[BIT_CHANGE_FLAG] && !chg.mismatch
            |=> !flags_second[BIT_CHANGE_FLAG])
        else $error("software clear of flag failed");
    ladder_bit_a: assert property (@(posedge clk) disable iff (!rst_n)
        !ladder_ctrl[BIT_LADDER_UNUSED])
        else $error("unused ladder bit stored");
    dir_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
        port_pin_oe_n[PIN_SECOND_OUT] == port_dir[PIN_SECOND_OUT])
        else $error("second pin enable ignores direction");
    second_invert_a: assert property (@(posedge clk) disable iff (!rst_n)
        cmp_active |-> second_result_async == (second_raw ^ ctrl_bits[BIT_SECOND_INVERT]))
        else $error("second inversion not applied");

    change_irq_c: cover property (@(posedge clk) disable iff (!rst_n)
        chg.mismatch ##1 irq_request);
    sleep_wake_c: cover property (@(posedge clk) disable iff (!rst_n)
        sleep ##[1:20] wake_request);
    routed_c: cover property (@(posedge clk) disable iff (!rst_n)
        route_pins && !port_pin_oe_n[PIN_FIRST_OUT]);
    flag_clear_c: cover property (@(posedge clk) disable iff (!rst_n)
        wr_flags && !reg_wdata[BIT_CHANGE_FLAG] ##1 !flags_second[BIT_CHANGE_FLAG]);
    ladder_feed_c: cover property (@(posedge clk) disable iff (!rst_n)
        $rose(ladder_to_comparators));
endmodule

// ### logic/cmp_pkg.sv
// Constants of the comparator control and reference ladder block.
// Assumes an 8-bit register port and a single clock domain.
package cmp_pkg;
    // ==============================================================
    // Register offsets
    localparam logic [7:0] OFS_PORT_A_DATA     = 8'h05;
    localparam logic [7:0] OFS_IRQ_GLOBAL      = 8'h0B;
    localparam logic [7:0] OFS_FLAGS_SECOND    = 8'h0D;
    localparam logic [7:0] OFS_PORT_A_DIR      = 8'h85;
    localparam logic [7:0] OFS_ENABLES_SECOND  = 8'h8D;
    localparam logic [7:0] OFS_CMP_CONTROL     = 8'h9C;
    localparam logic [7:0] OFS_LADDER_CONTROL  = 8'h9D;
    // ==============================================================
    // Reset values
    localparam logic [7:0] RST_CMP_CONTROL     = 8'h07;
    localparam logic [7:0] RST_LADDER_CONTROL  = 8'h00;
    localparam logic [7:0] RST_FLAGS_SECOND    = 8'h00;
    localparam logic [7:0] RST_ENABLES_SECOND  = 8'h00;
    localparam logic [7:0] RST_PORT_A_DIR      = 8'hFF;
    localparam logic [7:0] RST_IRQ_GLOBAL      = 8'h00;
    localparam logic [7:0] RST_PORT_A_LATCH    = 8'h00;
    // ==============================================================
    // Field positions
    localparam int unsigned BIT_SECOND_RESULT  = 7;
    localparam int unsigned BIT_FIRST_RESULT   = 6;
    localparam int unsigned BIT_SECOND_INVERT  = 5;
    localparam int unsigned BIT_FIRST_INVERT   = 4;
    localparam int unsigned BIT_INPUT_SWITCH   = 3;
    localparam int unsigned BIT_LADDER_POWER   = 7;
    localparam int unsigned BIT_LADDER_PIN     = 6;
    localparam int unsigned BIT_LADDER_RANGE   = 5;
    localparam int unsigned BIT_LADDER_UNUSED  = 4;
    localparam int unsigned BIT_GLOBAL_EN      = 7;
    localparam int unsigned BIT_PERIPH_EN      = 6;
    localparam int unsigned BIT_CHANGE_FLAG    = 6;
    localparam int unsigned PIN_LADDER         = 2;
    localparam int unsigned PIN_FIRST_OUT      = 3;
    localparam int unsigned PIN_SECOND_OUT     = 4;
    // Implemented bits of the flag and enable registers
    localparam logic [7:0] FLAGS_IMPL_MASK     = 8'hD0;
    // Direction bit of the input-only pin always reads one
    localparam logic [7:0] DIR_FORCED_MASK     = 8'h20;
    // ==============================================================
    // Mode codes and per-mode pin use
    localparam logic [2:0] MODE_LADDER_REF     = 3'b010;
    localparam logic [2:0] MODE_OFF            = 3'b111;
    localparam logic [7:0] PIN_OUT_MODES       = 8'h28;
    localparam logic [7:0] ANALOG_PINS_ROUTED  = 8'h07;
    localparam logic [7:0] ANALOG_PINS_PLAIN   = 8'h0F;
    localparam logic [7:0] ANALOG_PINS_NONE    = 8'h00;
endpackage

// ### test/cmp_analog_model.sv
// Far side of the comparator block: the two analog comparators and the port A pads.
// Assumes the bench drives the analog levels and the external pin levels.
`timescale 1ns/10ps
module cmp_analog_model (
    input  wire logic [7:0] first_plus,
    input  wire logic [7:0] first_minus,
    input  wire logic [7:0] second_plus,
    input  wire logic [7:0] second_minus,
    input  wire logic [7:0] ext_pins,
    input  wire logic [7:0] port_pin_out,
    input  wire logic [7:0] port_pin_oe_n,
    output logic            first_raw,
    output logic            second_raw,
    output logic      [7:0] port_pin_in
);
    // ==============================================================
    // Comparators: an equal pair reads low, as the analog stage would settle there
    assign first_raw  = (first_plus > first_minus);
    assign second_raw = (second_plus > second_minus);
    // ==============================================================
    // Pads: a driven pin shows the block's value, a released one the outside level
    assign port_pin_in = (~port_pin_oe_n & port_pin_out) | (port_pin_oe_n & ext_pins);
endmodule

// ### test/testbench.sv
// Self-checking bench for the comparator control block over its register port.
// Assumes the analog model of the comparators and pads in cmp_analog_model.
`timescale 1ns/10ps
module testbench;
    import cmp_pkg::*;
    logic       clk, rst_n, reg_wr, reg_rd, sleep, first_raw, second_raw;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, port_pin_in, port_pin_out, port_pin_oe_n;
    logic [7:0] first_plus, first_minus, second_plus, second_minus, ext_pins;
    logic       irq_request, wake_request, input_switch, ladder_power, ladder_pin_output;
    logic       ladder_range, ladder_to_comparators;
    logic [2:0] comparator_mode_field;
    logic [3:0] ladder_tap_value;
    int         err_count, compares, cycles;
    logic [7:0] mode_list [3] = '{8'h03, 8'h07, 8'h02};
    logic [7:0] port_exp  [3] = '{8'hF8, 8'hFF, 8'hF0};
    cmp_ctrl i_cmp_ctrl (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .first_raw(first_raw),
        .second_raw(second_raw), .port_pin_in(port_pin_in), .port_pin_out(port_pin_out),
        .port_pin_oe_n(port_pin_oe_n), .sleep(sleep), .irq_request(irq_request),
        .wake_request(wake_request), .comparator_mode_field(comparator_mode_field),
        .input_switch(input_switch), .ladder_power(ladder_power),
        .ladder_pin_output(ladder_pin_output), .ladder_range(ladder_range),
        .ladder_tap_value(ladder_tap_value), .ladder_to_comparators(ladder_to_comparators));
    cmp_analog_model i_cmp_analog_model (.first_plus(first_plus), .first_minus(first_minus),
        .second_plus(second_plus), .second_minus(second_minus), .ext_pins(ext_pins),
        .port_pin_out(port_pin_out), .port_pin_oe_n(port_pin_oe_n), .first_raw(first_raw),
        .second_raw(second_raw), .port_pin_in(port_pin_in));
    // ==============================================================
    // Clock, and a cycle ceiling well above the roughly 130 cycles the tests need
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            err_count++;
            close_out();
        end
    end
    // ==============================================================
    // Comparison and verdict
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic close_out();
        $display("mismatches %0d comparisons %0d", err_count, compares);
        if (err_count == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // ==============================================================
    // Register port: one-cycle strobes, read data only in the following cycle
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1;
        check($sformatf("register %h", a), reg_rdata, exp);
    endtask
    // ==============================================================
    // Main sequence
    initial begin
        {rst_n, reg_wr, reg_rd, sleep, reg_addr, reg_wdata} = '0;
        {first_plus, first_minus, second_plus, second_minus} = '0;
        ext_pins = 8'hFF;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        // Reset values, plus an unmapped place that reads zero
        check("oe_n", port_pin_oe_n, 8'hFF);
        rd(OFS_CMP_CONTROL, 8'h07);
        rd(OFS_LADDER_CONTROL, 8'h00);
        rd(OFS_FLAGS_SECOND, 8'h00);
        rd(OFS_ENABLES_SECOND, 8'h00);
        rd(OFS_PORT_A_DIR, 8'hFF);
        rd(8'h40, 8'h00);
        // Ladder control fields, with the unused bit written one
        wr(OFS_LADDER_CONTROL, 8'hFF);
        rd(OFS_LADDER_CONTROL, 8'hEF);
        check("ladder", {ladder_power, ladder_pin_output, ladder_range, 1'b0, ladder_tap_value},
              8'hEF);
        wr(OFS_LADDER_CONTROL, 8'h5A);
        rd(OFS_LADDER_CONTROL, 8'h4A);
        check("ladder", {ladder_power, ladder_pin_output, ladder_range, 1'b0, ladder_tap_value},
              8'h4A);
        wr(OFS_LADDER_CONTROL, 8'h80);
        check("ladder feed", {7'h0, ladder_to_comparators}, 8'h00);
        // Result bits written one must not stick
        wr(OFS_CMP_CONTROL, 8'hCA);
        check("ladder feed", {7'h0, ladder_to_comparators}, 8'h01);
        check("mode", {4'h0, input_switch, comparator_mode_field}, 8'h0A);
        repeat (6) @(posedge clk);
        rd(OFS_CMP_CONTROL, 8'h0A);
        // First result rises: flag, persisting mismatch, software clear and set
        @(posedge clk);
        first_plus <= 8'h80;
        repeat (6) @(posedge clk);
        rd(OFS_FLAGS_SECOND, 8'h40);
        check("irq", {7'h0, irq_request}, 8'h00);
        wr(OFS_FLAGS_SECOND, 8'h00);
        rd(OFS_FLAGS_SECOND, 8'h40);
        rd(OFS_CMP_CONTROL, 8'h4A);
        wr(OFS_FLAGS_SECOND, 8'h00);
        rd(OFS_FLAGS_SECOND, 8'h00);
        wr(OFS_FLAGS_SECOND, 8'h40);
        rd(OFS_FLAGS_SECOND, 8'h40);
        wr(OFS_ENABLES_SECOND, 8'h40);
        wr(OFS_IRQ_GLOBAL, 8'h40);
        check("irq", {7'h0, irq_request}, 8'h00);
        wr(OFS_IRQ_GLOBAL, 8'hC0);
        check("irq", {7'h0, irq_request}, 8'h01);
        wr(OFS_IRQ_GLOBAL, 8'h40);
        // Both inversions: first reads low, second reads high
        wr(OFS_CMP_CONTROL, 8'h32);
        repeat (6) @(posedge clk);
        rd(OFS_CMP_CONTROL, 8'hB2);
        // Routed mode with inversions, directions written to drive; the input-only pin stays released
        wr(OFS_CMP_CONTROL, 8'h33);
        wr(OFS_PORT_A_DIR, 8'h00);
        wr(OFS_PORT_A_DATA, 8'hA5);
        check("oe_n", port_pin_oe_n, 8'h20);
        check("pins", port_pin_out, 8'hB5);
        rd(OFS_PORT_A_DIR, 8'h20);
        // Port reads with pins released: analog pins read zero
        wr(OFS_PORT_A_DIR, 8'hFF);
        for (int i = 0; i < 3; i++) begin
            wr(OFS_CMP_CONTROL, mode_list[i]);
            repeat (4) @(posedge clk);
            rd(OFS_PORT_A_DATA, port_exp[i]);
        end
        // Comparators off before sleep; pending flag still wakes the device
        wr(OFS_CMP_CONTROL, 8'h07);
        @(posedge clk);
        sleep <= 1'b1;
        #1;
        check("wake", {7'h0, wake_request}, 8'h01);
        repeat (4) @(posedge clk); // Results pass three stages before reading back
        sleep <= 1'b0;
        rd(OFS_CMP_CONTROL, 8'h07);
        close_out();
    end
endmodule
